// file: design/odc_consts.svh
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH
// Register offset on the device's internal register bus.
`define ODC_DISCHARGE_OFFSET 8'h0F
// Register reset value.
`define ODC_DISCHARGE_RESET 8'h3F
// Field positions.
`define ODC_BIT_BUCK_LOAD 7
`define ODC_BIT_BOOST_LOAD 6
`define ODC_BIT_LIN_LO 2
`define ODC_BIT_STEP_UP_DIS 1
`define ODC_BIT_STEP_DOWN_DIS 0
`endif

// file: design/odc_pkg.sv
`include "odc_consts.svh"
package odc_pkg;
    // Register write request from the register file.
    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } odc_wr_t;
    // Per-regulator disable causes.
    typedef struct packed {
        logic enable_bit;
        logic seq_shutdown;
        logic over_voltage_event;
    } odc_cause_t;
    // Two-bit state of one discharge channel; RUN and IDLE codes differ in both bits.
    typedef enum logic [1:0] {
        ODC_RUN = 2'h0,
        ODC_DISCH = 2'h1,
        ODC_IDLE = 2'h3
    } odc_state_t;
endpackage : odc_pkg

// file: design/odc_chan.sv
`include "odc_consts.svh"
module odc_chan
    import odc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Discharge allowed and regulator disable request.
    input wire logic dis_en,
    input wire logic disabled,
    // Pull-down enable, registered.
    output logic pull_down
);
    // Channel state register.
    odc_state_t state_q;
    odc_state_t state_d;
    logic pd_d;

    // A disabled regulator discharges only when allowed; running one never does.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ODC_RUN: begin
                if (disabled) begin
                    state_d = dis_en ? ODC_DISCH : ODC_IDLE;
                end
            end
            ODC_DISCH: begin
                if (!disabled) begin
                    state_d = ODC_RUN;
                end else if (!dis_en) begin
                    state_d = ODC_IDLE;
                end
            end
            ODC_IDLE: begin
                if (!disabled) begin
                    state_d = ODC_RUN;
                end else if (dis_en) begin
                    state_d = ODC_DISCH;
                end
            end
            default: begin
                state_d = ODC_RUN;
            end
        endcase
        // The output follows the next state so it is itself a flip-flop.
        pd_d = (state_d == ODC_DISCH);
    end

    // Register the state and the output.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ODC_RUN;
            pull_down <= 1'h0;
        end else begin
            state_q <= state_d;
            pull_down <= pd_d;
        end
    end
endmodule : odc_chan

// file: design/odc_top.sv
`include "odc_consts.svh"
module odc_top
    import odc_pkg::*;
#(
    parameter int NUM_LIN = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Internal register port.
    input wire odc_wr_t wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // Hardware enable pin and boost enable pin.
    input wire logic hardware_enable_pin,
    input wire logic step_up_enable_pin,
    // Regulator causes: linear regulators, boost, buck.
    input wire odc_cause_t [NUM_LIN-1:0] lin_cause,
    input wire odc_cause_t step_up_cause,
    input wire odc_cause_t step_down_cause,
    // Operating mode of the switchers.
    input wire logic step_down_pulse_frequency_mode,
    input wire logic step_up_pulse_frequency_mode,
    // Load and pull-down controls, registered.
    output logic step_down_load_on,
    output logic step_up_load_on,
    output logic [NUM_LIN-1:0] linreg_pull_down,
    output logic step_up_pull_down,
    output logic step_down_pull_down
);
    // This block keeps the discharge control register and turns its bits into the enables of
    // the internal loads and of the active-discharge pull-downs on the six regulator outputs.
    // Every output is a flop, so a change of a bit or of a cause shows up one edge later.
    // The pull-downs are levels: they stand while a regulator is off and its discharge is allowed,
    // and they fall on the edge after the regulator runs again.
    // No output voltage is watched here; the block trusts the causes that it is handed.

    // Control register as it stands after the last accepted write.
    logic [7:0] ctrl_q;
    // Value the control register takes at the next edge.
    logic [7:0] ctrl_d;
    // Write strobe that names the control register.
    logic ctrl_hit;
    // Read data as they will be registered at the next edge.
    logic [7:0] rd_d;

    // Field view of the two load bits.
    logic step_down_load_sel;
    logic step_up_load_sel;
    // Next values of the two internal load controls.
    logic step_down_load_d;
    logic step_up_load_d;

    // Field view of the discharge allow bits.
    logic [NUM_LIN-1:0] linreg_discharge_en;
    logic step_up_discharge_en;
    logic step_down_discharge_en;

    // Individual disable triggers of the buck.
    logic step_down_pin_off;
    logic step_down_bit_off;
    logic step_down_seq_off;
    logic step_down_ov_off;

    // Individual disable triggers of the boost.
    logic step_up_pin_off;
    logic step_up_bit_off;
    logic step_up_ov_off;

    // Individual disable triggers of the linear regulators.
    logic [NUM_LIN-1:0] lin_pin_off;
    logic [NUM_LIN-1:0] lin_bit_off;
    logic [NUM_LIN-1:0] lin_seq_off;
    logic [NUM_LIN-1:0] lin_ov_off;

    // Combined disable request of every regulator.
    logic [NUM_LIN-1:0] lin_off;
    logic step_up_off;
    logic step_down_off;

    // Write decode: only a strobe that names this register's offset changes it.
    // Writes to other offsets are dropped silently, as other blocks own those addresses.
    always_comb begin
        ctrl_hit = wr.wr_en && (wr.addr == `ODC_DISCHARGE_OFFSET);
        // Hold the stored value unless the strobe hits.
        ctrl_d = ctrl_q;
        if (ctrl_hit) begin
            // All eight bits are writable; none is reserved.
            ctrl_d = wr.wdata;
        end
    end

    // Control register; the reset value allows every discharge path and removes both loads.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `ODC_DISCHARGE_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read decode: the register reads back as stored, every other offset reads zero.
    // A zero read does not tell the reader that an offset is unmapped; that is left to the bus.
    // The read path has no side effects, so reading never disturbs a discharge in progress.
    always_comb begin
        rd_d = 8'h00;
        if (rd_addr == `ODC_DISCHARGE_OFFSET) begin
            rd_d = ctrl_q;
        end
    end

    // Read data register; a read address is answered one edge later.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_d;
        end
    end

    // Buck load bit.
    assign step_down_load_sel = ctrl_q[`ODC_BIT_BUCK_LOAD];
    // Boost load bit.
    assign step_up_load_sel = ctrl_q[`ODC_BIT_BOOST_LOAD];
    // Boost discharge allow bit.
    assign step_up_discharge_en = ctrl_q[`ODC_BIT_STEP_UP_DIS];
    // Buck discharge allow bit.
    assign step_down_discharge_en = ctrl_q[`ODC_BIT_STEP_DOWN_DIS];

    // Internal loads: the load bit alone does nothing, the switcher must run in pulse-frequency mode too.
    // Leaving that mode removes the load at the next edge, without waiting for software.
    always_comb begin
        // Default: both loads removed.
        step_down_load_d = 1'h0;
        step_up_load_d = 1'h0;
        // Buck load.
        if (step_down_load_sel && step_down_pulse_frequency_mode) begin
            step_down_load_d = 1'h1;
        end
        // Boost load.
        if (step_up_load_sel && step_up_pulse_frequency_mode) begin
            step_up_load_d = 1'h1;
        end
    end

    // Load control flops; both loads are off while reset is held.
    // Each load control is a flop so that the switch it drives never sees a combinational glitch.
    always_ff @(posedge clk) begin
        if (rst) begin
            step_down_load_on <= 1'h0;
            step_up_load_on <= 1'h0;
        end else begin
            step_down_load_on <= step_down_load_d;
            step_up_load_on <= step_up_load_d;
        end
    end

    // Buck disable triggers, each kept apart so a probe can tell which one fired.
    // The hardware enable pin turns the buck off when it is low.
    assign step_down_pin_off = !hardware_enable_pin;
    // A cleared enable bit turns it off by software.
    assign step_down_bit_off = !step_down_cause.enable_bit;
    // The sequencer may take it down in a shutdown sequence.
    assign step_down_seq_off = step_down_cause.seq_shutdown;
    // An over-voltage event shuts it down as a fault.
    assign step_down_ov_off = step_down_cause.over_voltage_event;
    // Any one trigger is enough to ask for the buck discharge.
    assign step_down_off = step_down_pin_off || step_down_bit_off ||
                           step_down_seq_off || step_down_ov_off;

    // Boost disable triggers: its own enable pin, not the hardware enable pin.
    // The boost enable pin turns the boost off when it is low.
    assign step_up_pin_off = !step_up_enable_pin;
    // A cleared enable bit turns it off by software.
    assign step_up_bit_off = !step_up_cause.enable_bit;
    // An over-voltage event shuts it down as a fault.
    assign step_up_ov_off = step_up_cause.over_voltage_event;
    // A sequenced shutdown is not a boost trigger, so its seq_shutdown field stays unread.
    assign step_up_off = step_up_pin_off || step_up_bit_off || step_up_ov_off;

    // One channel per linear regulator; regulator one sits at the lowest linear field.
    // A count above four would reach into the load bits, so NUM_LIN is only sensible up to four.
    for (genvar i = 0; i < NUM_LIN; i++) begin : g_lin
        // Discharge allow bit of this regulator.
        assign linreg_discharge_en[i] = ctrl_q[`ODC_BIT_LIN_LO + i];
        // Triggers: the hardware pin is shared with the buck, the rest are per regulator.
        assign lin_pin_off[i] = !hardware_enable_pin;
        assign lin_bit_off[i] = !lin_cause[i].enable_bit;
        assign lin_seq_off[i] = lin_cause[i].seq_shutdown;
        assign lin_ov_off[i] = lin_cause[i].over_voltage_event;
        // Any one trigger is enough to ask for this regulator's discharge.
        assign lin_off[i] = lin_pin_off[i] || lin_bit_off[i] ||
                            lin_seq_off[i] || lin_ov_off[i];
        // Pull-down channel; it gates the request with the allow bit and registers the result.
        // The channel releases the pull-down on the edge after the regulator runs again.
        odc_chan u_chan (
            .clk(clk),
            .rst(rst),
            .dis_en(linreg_discharge_en[i]),
            .disabled(lin_off[i]),
            .pull_down(linreg_pull_down[i])
        );
    end

    // Boost pull-down channel; it never sees a sequenced shutdown.
    // Its allow bit is bit 1 of the register.
    odc_chan u_up (
        .clk(clk),
        .rst(rst),
        .dis_en(step_up_discharge_en),
        .disabled(step_up_off),
        .pull_down(step_up_pull_down)
    );

    // Buck pull-down channel.
    // Its allow bit is bit 0, the lowest field of the register.
    odc_chan u_down (
        .clk(clk),
        .rst(rst),
        .dis_en(step_down_discharge_en),
        .disabled(step_down_off),
        .pull_down(step_down_pull_down)
    );
endmodule : odc_top

// file: dv/odc_monitor.sv
`include "odc_consts.svh"
module odc_monitor
    import odc_pkg::*;
#(
    parameter int NUM_LIN = 4
) (
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic rst,
    input wire odc_wr_t wr,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Disable causes and modes.
    input wire logic hardware_enable_pin,
    input wire logic step_up_enable_pin,
    input wire odc_cause_t [NUM_LIN-1:0] lin_cause,
    input wire odc_cause_t step_up_cause,
    input wire odc_cause_t step_down_cause,
    input wire logic step_down_pulse_frequency_mode,
    input wire logic step_up_pulse_frequency_mode,
    // Load and pull-down outputs.
    input wire logic step_down_load_on,
    input wire logic step_up_load_on,
    input wire logic [NUM_LIN-1:0] linreg_pull_down,
    input wire logic step_up_pull_down,
    input wire logic step_down_pull_down
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A write that hits the control register.
    sequence s_wr_reg;
        wr.wr_en && wr.addr == `ODC_DISCHARGE_OFFSET;
    endsequence
    a_buck_load_mode:
        assert property (step_down_load_on |-> $past(step_down_pulse_frequency_mode))
            else $error("buck load outside pulse-frequency mode");
    a_boost_load_mode:
        assert property (step_up_load_on |-> $past(step_up_pulse_frequency_mode))
            else $error("boost load outside pulse-frequency mode");
    // Every linear channel may pull down only after one of its own causes.
    for (genvar i = 0; i < NUM_LIN; i++) begin : g_lin_chk
        a_lin_pull_cause:
            assert property (linreg_pull_down[i] |-> $past(!hardware_enable_pin || !lin_cause[i].enable_bit
                || lin_cause[i].seq_shutdown || lin_cause[i].over_voltage_event))
                else $error("lin pull-down without cause");
    end
    a_boost_pull_cause:
        assert property (step_up_pull_down |-> $past(!step_up_enable_pin || !step_up_cause.enable_bit
            || step_up_cause.over_voltage_event)) else $error("boost pull-down without cause");
    a_buck_pull_cause:
        assert property (step_down_pull_down |-> $past(!hardware_enable_pin || !step_down_cause.enable_bit
            || step_down_cause.seq_shutdown || step_down_cause.over_voltage_event)) else $error("buck pull-down bad");
    a_read_back:
        assert property (s_wr_reg ##1 (rd_addr == `ODC_DISCHARGE_OFFSET && !wr.wr_en) |=> rd_data == $past(wr.wdata, 2))
            else $error("readback differs");
    a_other_addr:
        assert property (rd_addr != `ODC_DISCHARGE_OFFSET |=> rd_data == 8'h00) else $error("unmapped read not zero");
    a_buck_bit_clear:
        assert property (s_wr_reg ##0 !wr.wdata[0] ##1 !wr.wr_en |=> !step_down_pull_down) else $error("buck pull on");
endmodule : odc_monitor

bind odc_top odc_monitor #(.NUM_LIN(NUM_LIN)) u_mon (.*);

// file: dv/tb_top.sv
`include "odc_consts.svh"
module tb_top
    import odc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    odc_wr_t wr = '0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data;
    logic hw = 1'b1;
    logic sup = 1'b1;
    odc_cause_t [3:0] lc = {4{3'b100}};
    odc_cause_t uc = 3'b100;
    odc_cause_t dc = 3'b100;
    logic pfm_d = 1'b0;
    logic pfm_u = 1'b0;
    logic ld_d, ld_u, pu_u, pu_d;
    logic [3:0] pl;
    int mismatches = 0;
    int check_count = 0;
    // Free-running 50 MHz clock.
    always #10 clk = ~clk;
    odc_top u_dut (.clk(clk), .rst(rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data), .hardware_enable_pin(hw),
        .step_up_enable_pin(sup), .lin_cause(lc), .step_up_cause(uc), .step_down_cause(dc),
        .step_down_pulse_frequency_mode(pfm_d), .step_up_pulse_frequency_mode(pfm_u), .step_down_load_on(ld_d),
        .step_up_load_on(ld_u), .linreg_pull_down(pl), .step_up_pull_down(pu_u), .step_down_pull_down(pu_d));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Inputs always move 2 ns after the edge so sampling never races.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wr = {1'b1, a, d};
        tick(1);
        wr.wr_en = 1'b0;
    endtask : wreg
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_addr = a;
        tick(1);
        chk(rd_data, exp);
    endtask : rd
    task automatic t_reg();
        rd(`ODC_DISCHARGE_OFFSET, `ODC_DISCHARGE_RESET);
        rd(8'h10, 8'h00);
        wreg(8'h10, 8'hAA);
        rd(`ODC_DISCHARGE_OFFSET, `ODC_DISCHARGE_RESET);
        wreg(`ODC_DISCHARGE_OFFSET, 8'hA5);
        rd(`ODC_DISCHARGE_OFFSET, 8'hA5);
    endtask : t_reg
    // Each cause in turn on each linear regulator, discharge allowed then barred.
    task automatic t_lin();
        for (int b = 0; b < 2; b++) begin
            wreg(8'h0F, b ? 8'h03 : 8'h3F);
            for (int i = 0; i < 4; i++) for (int k = 0; k < 4; k++) begin
                hw = (k != 0);
                lc[i] = {k != 1, k == 2, k == 3};
                tick(1);
                chk(pl, b ? 8'h00 : (k == 0 ? 8'h0F : 8'h01 << i));
                hw = 1'b1;
                lc[i] = 3'b100;
                tick(1);
                chk(pl, 8'h00);
            end
        end
    endtask : t_lin
    // Boost ignores sequenced shutdown and the hardware pin.
    task automatic t_switch();
        for (int b = 0; b < 2; b++) begin
            wreg(8'h0F, b ? 8'h3C : 8'h3F);
            for (int k = 0; k < 5; k++) begin
                sup = (k != 0);
                hw = (k != 4);
                uc = {k != 1, k == 2, k == 3};
                dc = uc;
                tick(1);
                chk({pu_u, pu_d}, b ? 8'h00 : k == 0 ? 8'h02 : (k == 2 || k == 4) ? 8'h01 : 8'h03);
                {sup, hw, uc, dc} = 8'hE4;
                tick(1);
                chk({pu_u, pu_d}, 8'h00);
            end
        end
    endtask : t_switch
    task automatic t_load();
        for (int m = 0; m < 4; m++) begin
            wreg(8'h0F, {m[1], m[0], 6'h00});
            // One mode at a time, so a swapped mode input shows up.
            pfm_d = 1'h1;
            tick(1);
            chk({ld_d, ld_u}, {m[1], 1'h0});
            pfm_d = 1'h0;
            pfm_u = 1'h1;
            tick(1);
            chk({ld_d, ld_u}, {1'h0, m[0]});
            pfm_u = 1'h0;
            tick(1);
            chk({ld_d, ld_u}, 8'h00);
        end
    endtask : t_load
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        tick(5);
        rst = 1'b0;
        t_reg();
        t_lin();
        t_switch();
        t_load();
        results();
    end
    // The whole run needs about 115 cycles; this cuts a hang short.
    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule : tb_top
